// File: sdc_pkg.sv
// Constants and carrier types for the speed droop compensation block
package sdc_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int CTRL_PERIOD_NS = 1000000;
   localparam int CTRL_CYCLES = CTRL_PERIOD_NS / CLK_PERIOD_NS;
   localparam int CTRL_PERIOD_US = CTRL_PERIOD_NS / 1000;
   localparam int TC_UNIT_US = 10000;
   localparam logic [6:0] TC_MAX = 7'h64;
   localparam logic [6:0] TC_DEFAULT = 7'h1E;
   localparam logic [6:0] GAIN_MAX = 7'h64;
   localparam logic [6:0] GAIN_DEFAULT = 7'h00;
   localparam int GAIN_DIV = 100;
   localparam logic signed [15:0] TRQ_RATED = 16'sh1000;
   localparam int TRQ_SHIFT = 12;
   localparam int COEF_FRAC = 16;
   localparam logic [16:0] COEF_ONE = 17'h10000;
   localparam logic [1:0] SEL_NO_RAMP = 2'h0;
   localparam logic [1:0] SEL_ZERO_LIM = 2'h1;
   localparam logic [1:0] SEL_NO_LIM = 2'h2;

   typedef struct packed {
      logic [6:0] droop_gain_setting;
      logic [6:0] droop_filter_time_constant;
      logic [1:0] droop_activation_select;
      logic vector_encoder_mode;
   } sdc_cfg_type;

   typedef struct packed {
      logic signed [15:0] speed_cmd;
      logic [15:0] rated_speed;
      logic ramping;
   } sdc_ref_type;

   typedef struct packed {
      logic signed [15:0] speed_corr;
      logic signed [15:0] droop_amount;
      logic droop_active;
   } sdc_out_type;
endpackage

// File: sdc_droop.sv
// Speed droop compensation: filtered torque lowers the speed command
//
// Behaviour
// RL1: droop = filtered torque / rated * speed*gain/100
// RL2: subtract droop from the speed command
// RL3: gain 0..100 percent, zero disables droop
// RL4: first-order lag filter, 0.00 to 1.00 s
// RL5: select 0: no droop while ramping
// RL6: select 0: negative corrected command clamps to zero
// RL7: select 1: always droop, clamp with encoder vector
// RL8: select 2: always droop, negative command allowed
// RL9: discrete lag per control cycle, zero bypasses
// RL10: upstream flags ramping acceleration or deceleration
`timescale 1ns/100ps
module sdc_droop #(
   parameter int CTRL_CYCLES = sdc_pkg::CTRL_CYCLES
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire sdc_pkg::sdc_cfg_type cfg,
   input wire sdc_pkg::sdc_ref_type ref_in,
   input wire logic signed [15:0] torque_current,
   output sdc_pkg::sdc_out_type out,
   output logic ctrl_tick
);
   logic [15:0] tick_cnt;
   logic signed [15:0] filt;
   logic signed [15:0] next_filt;
   sdc_pkg::sdc_out_type next_out;

   // Control cycle timebase
   wire tick_w = (tick_cnt == 16'(CTRL_CYCLES - 1));
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tick_cnt <= 16'h0000;
         ctrl_tick <= 1'b0;
      end else begin
         tick_cnt <= tick_w ? 16'h0000 : tick_cnt + 16'h0001;
         ctrl_tick <= tick_w;
      end
   end

   // Out-of-range settings saturate rather than wrap
   wire [6:0] gain_w = (cfg.droop_gain_setting > sdc_pkg::GAIN_MAX) ?
      sdc_pkg::GAIN_MAX : cfg.droop_gain_setting;
   wire [6:0] tc_w = (cfg.droop_filter_time_constant > sdc_pkg::TC_MAX) ?
      sdc_pkg::TC_MAX : cfg.droop_filter_time_constant;

   // Lag coefficient Ts/(T+Ts) in Q16; a divider traded for no lookup table
   wire [31:0] coef_num = 32'(sdc_pkg::CTRL_PERIOD_US) <<
      sdc_pkg::COEF_FRAC;
   wire [31:0] coef_den = 32'(sdc_pkg::CTRL_PERIOD_US) +
      32'(tc_w) * 32'(sdc_pkg::TC_UNIT_US);
   wire [31:0] coef_q = coef_num / coef_den;
   wire [16:0] coef_w = coef_q[16:0];
   wire signed [16:0] diff_w = 17'(torque_current) - 17'(filt);
   wire signed [34:0] step_w = 35'(diff_w) * 35'($signed({1'b0, coef_w}));
   wire signed [16:0] sum_w = 17'(filt) +
      17'(step_w >>> sdc_pkg::COEF_FRAC);

   always_comb begin
      next_filt = filt;
      if (ctrl_tick) begin
         if (tc_w == 7'h00) begin
            next_filt = torque_current; // RL9
         end else begin
            next_filt = sum_w[15:0]; // RL4 RL9
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         filt <= 16'sh0000;
      end else begin
         filt <= next_filt;
      end
   end

   // Droop amount, 100 percent torque is TRQ_RATED
   wire signed [47:0] prod_w = 48'(filt) * 48'($signed({1'b0,
      ref_in.rated_speed})) * 48'($signed({1'b0, gain_w}));
   wire signed [47:0] droop_w = (prod_w >>> sdc_pkg::TRQ_SHIFT) /
      48'(sdc_pkg::GAIN_DIV); // RL1

   function automatic logic signed [15:0] sat16(
      input logic signed [47:0] v);
      if (v > 48'sh7FFF) begin
         sat16 = 16'sh7FFF;
      end else if (v < -48'sh8000) begin
         sat16 = 16'sh8000;
      end else begin
         sat16 = v[15:0];
      end
   endfunction

   // Activation and clamp selection
   wire sel0 = (cfg.droop_activation_select == sdc_pkg::SEL_NO_RAMP);
   wire sel1 = (cfg.droop_activation_select == sdc_pkg::SEL_ZERO_LIM);
   wire sel2 = (cfg.droop_activation_select == sdc_pkg::SEL_NO_LIM);
   // Code 3 is undefined; it behaves as select 0, the safest mode
   wire sel_ramp_block = !sel1 && !sel2;
   // Ramping comes from the reference generator on this clock
   wire apply_w = (gain_w != 7'h00) && // RL3
      !(sel_ramp_block && ref_in.ramping); // RL5 RL10
   wire clamp_w = sel_ramp_block || // RL6
      (sel1 && cfg.vector_encoder_mode); // RL7
   wire signed [47:0] corr_w = 48'(ref_in.speed_cmd) - droop_w; // RL2
   wire neg_w = corr_w[47];

   always_comb begin
      next_out.droop_active = apply_w;
      next_out.droop_amount = apply_w ? sat16(droop_w) : 16'sh0000;
      if (!apply_w) begin
         next_out.speed_corr = ref_in.speed_cmd;
      end else if (neg_w && clamp_w) begin
         next_out.speed_corr = 16'sh0000; // RL6 RL7
      end else begin
         next_out.speed_corr = sat16(corr_w); // RL2 RL8
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         out <= '0;
      end else begin
         out <= next_out;
      end
   end

   // Checks rest while reset is held
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   wire in_range_w = (corr_w >= -48'sh8000) && (corr_w <= 48'sh7FFF);

   a_gain_zero_off: assert property ( // RL3
      (cfg.droop_gain_setting == 7'h00) |=>
      (out.speed_corr == $past(ref_in.speed_cmd)) && !out.droop_active)
      else $error("zero gain must pass the command unchanged");

   a_ramp_blocks: assert property ( // RL5
      (sel0 && ref_in.ramping) |=> !out.droop_active &&
      (out.speed_corr == $past(ref_in.speed_cmd)))
      else $error("select 0 applied droop while ramping");

   a_sel0_clamp: assert property ( // RL6
      (sel0 && apply_w) |=> !out.speed_corr[15])
      else $error("select 0 let the command go negative");

   a_sel1_enc_clamp: assert property ( // RL7
      (sel1 && apply_w && cfg.vector_encoder_mode) |=> !out.speed_corr[15])
      else $error("select 1 with encoder did not clamp");

   a_sel1_open_neg: assert property ( // RL7
      (sel1 && apply_w && !cfg.vector_encoder_mode && neg_w) |=>
      out.speed_corr[15] && out.droop_active)
      else $error("select 1 without encoder clamped or skipped droop");

   a_sel2_neg_pass: assert property ( // RL8
      (sel2 && apply_w && neg_w && in_range_w) |=>
      out.speed_corr[15] && out.droop_active)
      else $error("select 2 clamped a negative command");

   a_droop_lowers: assert property ( // RL2
      (apply_w && filt > 16'sh0000 && !ref_in.speed_cmd[15]) |=>
      (out.speed_corr <= $past(ref_in.speed_cmd)))
      else $error("positive load did not lower the command");

   a_full_scale: assert property ( // RL1
      (filt == sdc_pkg::TRQ_RATED &&
      cfg.droop_gain_setting == sdc_pkg::GAIN_MAX &&
      apply_w && !ref_in.rated_speed[15]) |=>
      (out.droop_amount == $signed($past(ref_in.rated_speed))))
      else $error("rated torque at full gain must droop rated speed");

   a_filter_bypass: assert property ( // RL9
      (ctrl_tick && cfg.droop_filter_time_constant == 7'h00) |=>
      (filt == $past(torque_current)))
      else $error("zero time constant must bypass the filter");

   a_filter_hold: assert property ( // RL4
      !ctrl_tick |=> $stable(filt))
      else $error("filter moved outside a control cycle");

   a_tick_spacing: assert property ( // RL9
      ctrl_tick |=> !ctrl_tick)
      else $error("control cycle ticks back to back");

   a_sel1_ramp_on: assert property ( // RL7
      (sel1 && gain_w != 7'h00 && ref_in.ramping) |=> out.droop_active)
      else $error("select 1 skipped droop while ramping");

   a_sel2_ramp_on: assert property ( // RL8
      (sel2 && gain_w != 7'h00 && ref_in.ramping) |=> out.droop_active)
      else $error("select 2 skipped droop while ramping");

   // Rounding of the lag step must never overshoot the target
   a_lag_rise: assert property ( // RL4
      (ctrl_tick && tc_w != 7'h00 && torque_current >= filt) |=>
      (filt >= $past(filt)) && (filt <= $past(torque_current)))
      else $error("lag step left the rising span");

   a_lag_fall: assert property ( // RL4
      (ctrl_tick && tc_w != 7'h00 && torque_current <= filt) |=>
      (filt <= $past(filt)) && (filt >= $past(torque_current)))
      else $error("lag step left the falling span");

   a_droop_idle: assert property ( // RL3
      !out.droop_active |-> (out.droop_amount == 16'sh0000))
      else $error("droop amount shown while droop is off");

   // Main scenarios for coverage
   c_steady_droop: cover property (sel0 && apply_w ##1 out.droop_active);
   c_zero_clamp: cover property (apply_w && clamp_w && neg_w);
   c_negative_out: cover property (sel2 && apply_w ##1 out.speed_corr[15]);
   c_filter_step: cover property (ctrl_tick && tc_w != 7'h00 &&
      diff_w != 17'sh00000);
   c_ramp_droop: cover property ((sel1 || sel2) && apply_w &&
      ref_in.ramping);
endmodule

// File: sdc_load_model.sv
// Torque current measurement model for the droop bench
`timescale 1ns/100ps
module sdc_load_model (
   input wire logic core_clk,
   input wire logic signed [15:0] load_level,
   output logic signed [15:0] torque_current
);
   logic signed [15:0] sensed = 16'sh0000;
   initial torque_current = 16'sh0000;
   // Sensed on the rising edge, so a level set at the falling edge
   // never races; shown on the next falling edge
   always @(posedge core_clk) begin
      sensed <= load_level;
   end
   always @(negedge core_clk) begin
      torque_current <= sensed;
   end
endmodule

// File: tb_speed_droop_compensation.sv
// Self-checking bench for the speed droop compensation block
`timescale 1ns/100ps
module tb_speed_droop_compensation;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   sdc_pkg::sdc_cfg_type cfg;
   sdc_pkg::sdc_ref_type ref_in;
   logic signed [15:0] load_level = 16'sh0000;
   logic signed [15:0] torque_current;
   sdc_pkg::sdc_out_type out;
   logic ctrl_tick;
   int failures = 0;
   int n_tests = 0;
   localparam int TB_CTRL = 8;

   always #25 core_clk = ~core_clk;

   sdc_load_model sdc_load_model_i (
      .core_clk(core_clk),
      .load_level(load_level),
      .torque_current(torque_current)
   );

   // Short control cycle keeps the run brief
   sdc_droop #(.CTRL_CYCLES(TB_CTRL)) sdc_droop_i (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .cfg(cfg),
      .ref_in(ref_in),
      .torque_current(torque_current),
      .out(out),
      .ctrl_tick(ctrl_tick)
   );

   task automatic conclude;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Command 1000, rated 1500; called just after a falling edge
   task automatic setup(input logic [6:0] gain, input logic [6:0] tc,
                        input logic [1:0] sel, input logic enc,
                        input logic ramp, input logic signed [15:0] load);
      cfg = '{gain, tc, sel, enc};
      ref_in = '{16'sh03E8, 16'h05DC, ramp};
      load_level = load;
   endtask

   // Filter update edge, then one more edge for the output
   task automatic wait_tick;
      for (int i = 0; i < 40 && ctrl_tick !== 1'b1; i++) @(negedge core_clk);
      if (ctrl_tick !== 1'b1) begin
         failures++;
         $display("BAD ctrl_tick expected 1 seen %b", ctrl_tick);
      end else begin
         @(negedge core_clk);
         @(negedge core_clk);
      end
   endtask

   task automatic step(input logic [6:0] gain, input logic [1:0] sel,
                       input logic enc, input logic ramp);
      setup(gain, 7'h00, sel, enc, ramp, 16'sh1000);
      @(negedge core_clk);
   endtask

   task automatic sc_full_droop;
      setup(7'h64, 7'h00, 2'h2, 1'b0, 1'b0, 16'sh1000);
      wait_tick();
      chk("corr select 2", 16'hFE0C, out.speed_corr);
      chk("droop amount", 16'h05DC, out.droop_amount);
      chk("active select 2", 16'h0001, {15'h0, out.droop_active});
   endtask

   task automatic sc_selects;
      step(7'h64, 2'h1, 1'b0, 1'b0);
      chk("corr select 1 open", 16'hFE0C, out.speed_corr);
      step(7'h64, 2'h1, 1'b1, 1'b0);
      chk("corr select 1 encoder", 16'h0000, out.speed_corr);
      step(7'h64, 2'h0, 1'b0, 1'b0);
      chk("corr select 0 steady", 16'h0000, out.speed_corr);
      step(7'h64, 2'h0, 1'b0, 1'b1);
      chk("corr select 0 ramp", 16'h03E8, out.speed_corr);
      chk("active ramp", 16'h0000, {15'h0, out.droop_active});
      step(7'h64, 2'h1, 1'b0, 1'b1);
      chk("corr select 1 ramp", 16'hFE0C, out.speed_corr);
      step(7'h64, 2'h2, 1'b0, 1'b1);
      chk("corr select 2 ramp", 16'hFE0C, out.speed_corr);
      chk("active select 2 ramp", 16'h0001, {15'h0, out.droop_active});
      step(7'h64, 2'h3, 1'b0, 1'b1);
      chk("corr select 3 ramp", 16'h03E8, out.speed_corr);
      step(7'h64, 2'h3, 1'b0, 1'b0);
      chk("corr select 3 steady", 16'h0000, out.speed_corr);
   endtask

   task automatic sc_gain_zero;
      step(7'h00, 2'h2, 1'b0, 1'b0);
      chk("corr gain 0", 16'h03E8, out.speed_corr);
      chk("active gain 0", 16'h0000, {15'h0, out.droop_active});
      chk("droop gain 0", 16'h0000, out.droop_amount);
      step(7'h32, 2'h2, 1'b0, 1'b0);
      chk("corr gain 50", 16'h00FA, out.speed_corr);
      chk("droop gain 50", 16'h02EE, out.droop_amount);
      step(7'h7F, 2'h2, 1'b0, 1'b0);
      chk("corr gain over", 16'hFE0C, out.speed_corr);
   endtask

   // Settle 4096 first, so the lag step never meets a tick mid-setup
   // Default lag 0.3 s: one step from 4096 towards 0 gives 4082
   task automatic sc_lag;
      setup(7'h64, 7'h00, 2'h2, 1'b0, 1'b0, 16'sh1000);
      wait_tick();
      setup(7'h64, sdc_pkg::TC_DEFAULT, 2'h2, 1'b0, 1'b0, 16'sh0000);
      wait_tick();
      chk("corr lag", 16'hFE12, out.speed_corr);
      chk("droop lag", 16'h05D6, out.droop_amount);
   endtask

   // Mid-run reset clears the filter; first tick after TB_CTRL edges
   task automatic sc_reset;
      int n;
      setup(7'h64, 7'h00, 2'h2, 1'b0, 1'b0, 16'sh1000);
      rst_b = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("mid reset corr", 16'h0000, out.speed_corr);
      chk("mid reset tick", 16'h0000, {15'h0, ctrl_tick});
      rst_b = 1'b1;
      @(negedge core_clk);
      chk("corr after reset", 16'h03E8, out.speed_corr);
      chk("droop after reset", 16'h0000, out.droop_amount);
      for (n = 1; n < 40 && ctrl_tick !== 1'b1; n++) @(negedge core_clk);
      chk("tick after reset", 16'(TB_CTRL), 16'(n));
      repeat (2) @(negedge core_clk);
      chk("corr first tick", 16'hFE0C, out.speed_corr);
   endtask

   initial begin
      setup(sdc_pkg::GAIN_DEFAULT, sdc_pkg::TC_DEFAULT, 2'h0, 1'b0, 1'b0,
            16'sh0000);
      repeat (8) @(negedge core_clk);
      chk("reset corr", 16'h0000, out.speed_corr);
      chk("reset tick", 16'h0000, {15'h0, ctrl_tick});
      rst_b = 1'b1;
      sc_full_droop();
      sc_selects();
      sc_gain_zero();
      sc_lag();
      sc_reset();
      conclude();
   end
endmodule
